/* core/evpu_map.vh */
/*
  Constants for the exception vector priority unit: vector layout,
  priority level encoding, relocation window and implemented-source masks.
  Assumes inclusion by the core and sim files; holds definitions and nothing else.
*/
`ifndef EVPU_MAP_VH
`define EVPU_MAP_VH

// Vector numbering
`define EVPU_NUM_VEC        64
`define EVPU_IRQ_COUNT      48
`define EVPU_IRQ_BASE       6'h10
`define EVPU_VEC_SP         6'h00
`define EVPU_VEC_RESET      6'h01
`define EVPU_VEC_NMI        6'h02
`define EVPU_VEC_HARDFAULT  6'h03

// Interrupt lines with a source; zero bits are reserved numbers
`define EVPU_IRQ_IMPL_MASK  48'hE880_31FF_DFBF
// Processor exception vectors 0..15 that exist
`define EVPU_SYS_IMPL_MASK  16'hD87E

// Level code = priority + 3, so reset -3 maps to 0
`define EVPU_LVL_RESET      4'h0
`define EVPU_LVL_NMI        4'h1
`define EVPU_LVL_HARDFAULT  4'h2
`define EVPU_LVL_CFG_BASE   4'h3
`define EVPU_LVL_NONE       4'hF
`define EVPU_PRIO_RESET     3'h0

// Vector table base
`define EVPU_BASE_RESET     32'h0000_0000
`define EVPU_BASE_MIN       32'h0000_0100
`define EVPU_BASE_MAX       32'h3FFF_FF00
`define EVPU_BASE_ALIGN_LSB 8

`endif

/* core/evpu_vec_table.v */
/*
  Vector table store: entry 0 holds the initial stack pointer, entry n the
  handler start address of exception vector n. Registered read port.
  Assumes the caller qualifies writes (privilege) and supplies one clock.
*/
`timescale 1ns/1ns
`default_nettype none

module evpu_vec_table #(
  parameter DEPTH = 64,
  parameter AW    = 6,
  parameter DW    = 32
) (
  // Clock
  input  wire          clk_i,
  // Write port
  input  wire          wr_i,
  input  wire [AW-1:0] wr_idx_i,
  input  wire [DW-1:0] wr_data_i,
  // Read port
  input  wire [AW-1:0] rd_idx_i,
  output reg  [DW-1:0] rd_data_o
);

  reg [DW-1:0] mem [0:DEPTH-1];

  // No reset on the array so it maps onto RAM
  always @(posedge clk_i) begin
    if (wr_i) begin
      mem[wr_idx_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_idx_i];
  end

endmodule // evpu_vec_table

`default_nettype wire

/* core/evpu_core.v */
/*
  Exception vector priority unit: tracks pending and active exceptions,
  picks the most urgent, decides preemption, forms vector fetch addresses.
  Assumes a single 10 MHz clock, synchronous request inputs and a core
  that acknowledges the offered vector and reports handler returns.
*/
`timescale 1ns/1ns
`default_nettype none
`include "evpu_map.vh"

// What this block does
// RULE1: Interrupt lines 0..47 map to exception vectors 16..63; 0..15 are processor exceptions.
// RULE2: Table entry zero holds initial stack pointer, then one handler address per vector.
// RULE3: Software sets bit zero of every handler address it stores.
// RULE4: Every reset returns the vector table base to address zero.
// RULE5: Base relocation only by privileged writes inside 0x100..0x3FFFFF00.
// RULE6: Software picks a relocated base on a 256-byte boundary.
// RULE7: A smaller priority value is more urgent.
// RULE8: All priorities configurable except reset, hard fault and NMI.
// RULE9: Configurable priorities start at zero after reset.
// RULE10: Configurable levels span 0..7; fixed negative levels always outrank them.
// RULE11: Equal priority ties go to the lowest exception number.
// RULE12: A running handler is preempted only by a strictly more urgent exception.
// RULE13: Equal priority never preempts; the newcomer just stays pending.
// RULE14: Reserved interrupt numbers have no source and no vector.
// RULE15: Reset -3, NMI -2, hard fault -1; NMI can never be masked.
// RULE16: Preemption compares group priority only; subpriority orders pending ones.
// RULE17: Each configurable priority is a three-bit field.
// RULE18: Fetch address is table base plus four times the vector number.
module evpu_core #(
  parameter NUM_VEC = `EVPU_NUM_VEC,
  parameter NUM_IRQ = `EVPU_IRQ_COUNT
) (
  // Clock and reset
  input  wire               clk_i,
  input  wire               resetn_i,
  // Request sources
  input  wire [NUM_IRQ-1:0] irq_i,
  input  wire [15:0]        sys_req_i,
  // Configuration port
  input  wire               cfg_priv_i,
  input  wire               cfg_prio_wr_i,
  input  wire [5:0]         cfg_prio_num_i,
  input  wire [2:0]         cfg_prio_val_i,
  input  wire [1:0]         cfg_sub_bits_i,
  input  wire               cfg_base_wr_i,
  input  wire [31:0]        cfg_base_val_i,
  input  wire               cfg_tbl_wr_i,
  input  wire [5:0]         cfg_tbl_idx_i,
  input  wire [31:0]        cfg_tbl_data_i,
  // Core side
  input  wire               core_ack_i,
  input  wire               core_ret_i,
  input  wire [5:0]         core_ret_num_i,
  output reg                exc_req_o,
  output reg  [5:0]         exc_num_o,
  output reg  [3:0]         exc_level_o,
  output reg  [31:0]        exc_fetch_addr_o,
  output wire [31:0]        exc_handler_o,
  // Status
  output reg  [31:0]        vector_base_offset_reg_o,
  output reg  [NUM_VEC-1:0] pending_o,
  output reg  [NUM_VEC-1:0] active_o,
  output reg                cfg_err_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Group part of an encoded level; fixed levels are their own group
  function [3:0] evpu_group;
    input [3:0] lvl;
    input [1:0] sub;
    reg   [3:0] d;
    reg   [2:0] p;
    begin
      d = 4'h0;
      p = 3'h0;
      if (lvl < `EVPU_LVL_CFG_BASE || lvl == `EVPU_LVL_NONE) begin
        evpu_group = lvl;
      end else begin
        d = lvl - `EVPU_LVL_CFG_BASE;
        p = d[2:0] >> sub;
        evpu_group = `EVPU_LVL_CFG_BASE + {1'b0, p};
      end
    end
  endfunction

  // True for vectors whose priority software may set
  function evpu_is_cfg;
    input [5:0] num;
    reg   [63:0] impl;
    begin
      impl = {`EVPU_IRQ_IMPL_MASK, `EVPU_SYS_IMPL_MASK};
      evpu_is_cfg = impl[num] && (num > `EVPU_VEC_HARDFAULT);          // RULE8 RULE14
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Request sources

  wire [63:0] impl_mask = {`EVPU_IRQ_IMPL_MASK, `EVPU_SYS_IMPL_MASK};
  // Interrupt n lands on vector n + 16; reserved lines are cut off
  wire [63:0] raw_req   = {irq_i, sys_req_i} & impl_mask;              // RULE1 RULE14

  ////////////////////////////////////////////////////////////////////////////
  // Priority store

  reg  [2:0] prio_cfg [0:NUM_VEC-1];
  wire [3:0] lvl      [0:NUM_VEC-1];
  integer    k;

  wire prio_wr_ok = cfg_prio_wr_i && cfg_priv_i && evpu_is_cfg(cfg_prio_num_i);
  wire base_in_range = (cfg_base_val_i >= `EVPU_BASE_MIN) &&
                       (cfg_base_val_i <= `EVPU_BASE_MAX);
  wire base_wr_ok = cfg_base_wr_i && cfg_priv_i && base_in_range;      // RULE5

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (k = 0; k < NUM_VEC; k = k + 1) begin
        prio_cfg[k] <= `EVPU_PRIO_RESET;                               // RULE9
      end
    end else if (prio_wr_ok) begin
      // Three-bit field: levels above 7 cannot be written
      prio_cfg[cfg_prio_num_i] <= cfg_prio_val_i;                      // RULE17 RULE10
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_VEC; g = g + 1) begin : g_lvl
      if (g == 1) begin : g_rst
        assign lvl[g] = `EVPU_LVL_RESET;                               // RULE15
      end else if (g == 2) begin : g_nmi
        assign lvl[g] = `EVPU_LVL_NMI;                                 // RULE15
      end else if (g == 3) begin : g_hf
        assign lvl[g] = `EVPU_LVL_HARDFAULT;                           // RULE15
      end else begin : g_cfg
        // Negative fixed levels sit below every configurable code
        assign lvl[g] = `EVPU_LVL_CFG_BASE + {1'b0, prio_cfg[g]};      // RULE10 RULE7
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Vector table base and error flag

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vector_base_offset_reg_o <= `EVPU_BASE_RESET;                    // RULE4
      cfg_err_o                <= 1'b0;
    end else begin
      if (base_wr_ok) begin
        // Low bits dropped so a misaligned base cannot reach the fetch adder
        vector_base_offset_reg_o <= {cfg_base_val_i[31:`EVPU_BASE_ALIGN_LSB],
                                     {`EVPU_BASE_ALIGN_LSB{1'b0}}};    // RULE6
      end
      cfg_err_o <= (cfg_base_wr_i && !base_wr_ok) ||
                   (cfg_prio_wr_i && !prio_wr_ok) ||
                   (cfg_tbl_wr_i && !cfg_priv_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Selection of the most urgent pending exception

  reg [5:0] next_num;
  reg [3:0] next_lvl;
  reg       next_found;
  reg [3:0] act_group;
  reg       next_req;
  integer   i;

  always @* begin
    next_num   = 6'h00;
    next_lvl   = `EVPU_LVL_NONE;
    next_found = 1'b0;
    act_group  = `EVPU_LVL_NONE;
    for (i = 0; i < NUM_VEC; i = i + 1) begin
      // Strict compare keeps the lowest number on a tie
      if (pending_o[i] && lvl[i] < next_lvl) begin                     // RULE11 RULE7
        next_num   = i[5:0];
        next_lvl   = lvl[i];
        next_found = 1'b1;
      end
      if (active_o[i] && evpu_group(lvl[i], cfg_sub_bits_i) < act_group) begin
        act_group = evpu_group(lvl[i], cfg_sub_bits_i);                // RULE16
      end
    end
    // Full level orders pending; only group level may preempt
    next_req = next_found &&
               (evpu_group(next_lvl, cfg_sub_bits_i) < act_group);     // RULE12 RULE13 RULE16
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending and active state

  wire        take    = exc_req_o && core_ack_i;
  wire [63:0] take_oh = take ? ({{63{1'b0}}, 1'b1} << exc_num_o) : 64'h0000_0000_0000_0000;
  wire [63:0] ret_oh  = core_ret_i ? ({{63{1'b0}}, 1'b1} << core_ret_num_i)
                                   : 64'h0000_0000_0000_0000;

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      // Reset exception is offered first after release
      pending_o <= {{62{1'b0}}, 1'b1, 1'b0};
      active_o  <= {NUM_VEC{1'b0}};
    end else begin
      // A request in the clear cycle survives; equal levels wait here
      pending_o <= (pending_o & ~take_oh) | raw_req;                   // RULE13
      active_o  <= (active_o & ~ret_oh) | take_oh;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Offer to the core

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      exc_req_o        <= 1'b0;
      exc_num_o        <= 6'h00;
      exc_level_o      <= `EVPU_LVL_NONE;
      exc_fetch_addr_o <= `EVPU_BASE_RESET;
    end else if (take) begin
      // Drop for a cycle so the selection sees the updated state
      exc_req_o <= 1'b0;
    end else begin
      exc_req_o        <= next_req;
      exc_num_o        <= next_num;
      exc_level_o      <= next_lvl;
      exc_fetch_addr_o <= vector_base_offset_reg_o +
                          {24'h00_0000, next_num, 2'b00};              // RULE18
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Vector table

  wire [5:0] tbl_rd_idx = take ? exc_num_o : next_num;

  // Entry 0 is the stack pointer, later entries are handlers
  evpu_vec_table #(
    .DEPTH (NUM_VEC),
    .AW    (6),
    .DW    (32)
  ) u_table (
    .clk_i     (clk_i),
    .wr_i      (cfg_tbl_wr_i && cfg_priv_i),                           // RULE2
    .wr_idx_i  (cfg_tbl_idx_i),
    .wr_data_i (cfg_tbl_data_i),
    .rd_idx_i  (tbl_rd_idx),
    .rd_data_o (exc_handler_o)
  );

endmodule // evpu_core

`default_nettype wire

/* sim/evpu_props.sv */
/*
  Checker for evpu_core, bound to its ports.
  Assumes one clock domain and the level codes of evpu_map.vh.
*/
`timescale 1ns/1ns
`default_nettype none
`include "evpu_map.vh"
module evpu_props #(
  parameter NUM_VEC = 64
) (
  // Clock and reset
  input wire logic               clk_i,
  input wire logic               resetn_i,
  // Configuration
  input wire logic               cfg_priv_i,
  input wire logic               cfg_prio_wr_i,
  input wire logic [5:0]         cfg_prio_num_i,
  input wire logic               cfg_base_wr_i,
  // Offer and state
  input wire logic               exc_req_o,
  input wire logic [5:0]         exc_num_o,
  input wire logic [3:0]         exc_level_o,
  input wire logic [31:0]        exc_fetch_addr_o,
  input wire logic [31:0]        vector_base_offset_reg_o,
  input wire logic [NUM_VEC-1:0] pending_o,
  input wire logic               cfg_err_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  chk_reset_offer: assert property ($rose(resetn_i) |=> exc_req_o && exc_num_o == 6'h01)
    else $error("reset vector not offered");
  chk_fetch_addr: assert property (exc_req_o && $stable(vector_base_offset_reg_o) |->
    exc_fetch_addr_o == vector_base_offset_reg_o + {24'h00_0000, exc_num_o, 2'b00})
    else $error("fetch address mismatch");
  chk_base_window: assert property (vector_base_offset_reg_o[7:0] == 8'h00 &&
    (vector_base_offset_reg_o == 32'h0000_0000 || (vector_base_offset_reg_o >= `EVPU_BASE_MIN
    && vector_base_offset_reg_o <= `EVPU_BASE_MAX))) else $error("base outside window");
  chk_base_refuse: assert property (cfg_base_wr_i && !cfg_priv_i |=>
    cfg_err_o && $stable(vector_base_offset_reg_o)) else $error("unprivileged base write");
  chk_fixed_prio: assert property (cfg_prio_wr_i && cfg_prio_num_i < 6'h04 |=> cfg_err_o)
    else $error("fixed priority write accepted");
  chk_fixed_level: assert property (exc_req_o && exc_num_o inside {[1:3]} |->
    exc_level_o == exc_num_o[3:0] - 4'h1) else $error("fixed level wrong");
  chk_cfg_range: assert property (exc_req_o && exc_num_o > 6'h03 |->
    exc_level_o inside {[4'h3:4'hA]}) else $error("configurable level out of range");
  chk_no_reserved: assert property ((pending_o[63:16] & ~`EVPU_IRQ_IMPL_MASK) == 48'h0)
    else $error("reserved line pending");
endmodule // evpu_props
bind evpu_core evpu_props #(.NUM_VEC(NUM_VEC)) u_props (.clk_i, .resetn_i, .cfg_priv_i,
  .cfg_prio_wr_i, .cfg_prio_num_i, .cfg_base_wr_i, .exc_req_o, .exc_num_o, .exc_level_o,
  .exc_fetch_addr_o, .vector_base_offset_reg_o, .pending_o, .cfg_err_o);
`default_nettype wire

/* sim/evpu_cpu_model.sv */
/*
  Processor core stand-in: takes offered vectors after 0..3 cycles, records them.
  Assumes the offer ports of evpu_core and one clock.
*/
`timescale 1ns/1ns
`default_nettype none
module evpu_cpu_model (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // Offer
  input  wire logic        exc_req_i,
  input  wire logic [5:0]  exc_num_i,
  input  wire logic [31:0] exc_handler_i,
  input  wire logic [1:0]  delay_i,
  // Take and record
  output var  logic        core_ack_o,
  output var  logic [5:0]  last_num_o,
  output var  logic [31:0] last_handler_o,
  output var  int          takes_o
);
  logic [1:0] wait_cnt;
  initial takes_o = 0;
  // Off the sampling edge; never two acks in a row
  always @(negedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      core_ack_o <= 1'b0;
      wait_cnt   <= 2'h0;
    end else begin
      core_ack_o <= exc_req_i && !core_ack_o && wait_cnt >= delay_i;
      wait_cnt   <= (exc_req_i && !core_ack_o) ? wait_cnt + 2'h1 : 2'h0;
    end
  end
  always @(posedge clk_i) begin
    if (resetn_i && core_ack_o && exc_req_i) begin
      last_num_o     <= exc_num_i;
      last_handler_o <= exc_handler_i;
      takes_o        <= takes_o + 1;
    end
  end
endmodule // evpu_cpu_model
`default_nettype wire

/* sim/tb_top.sv */
/*
  Self-checking bench for evpu_core with a core stand-in.
  Assumes evpu_map.vh on the include path.
*/
`timescale 1ns/1ns
`default_nettype none
`include "evpu_map.vh"
module tb_top;
  logic        clk_i, resetn_i, priv, pwr, bwr, twr, ret, ack, req, err;
  logic [47:0] irq;
  logic [15:0] sys;
  logic [5:0]  pnum, rnum, tidx, num, lnum;
  logic [2:0]  pval, pa, pb;
  logic [1:0]  dly, sub;
  logic [3:0]  lvl;
  logic [31:0] bval, tdata, base, fetch, hdl, lhdl, eb;
  logic [63:0] pend, act;
  int          takes, fail_count, checks, seed, k, a, b, f;
  evpu_core u_evpu_core (.clk_i(clk_i), .resetn_i(resetn_i), .irq_i(irq), .sys_req_i(sys),
    .cfg_priv_i(priv), .cfg_prio_wr_i(pwr), .cfg_prio_num_i(pnum), .cfg_prio_val_i(pval),
    .cfg_sub_bits_i(sub), .cfg_base_wr_i(bwr), .cfg_base_val_i(bval), .cfg_tbl_wr_i(twr),
    .cfg_tbl_idx_i(tidx), .cfg_tbl_data_i(tdata), .core_ack_i(ack), .core_ret_i(ret),
    .core_ret_num_i(rnum), .exc_req_o(req), .exc_num_o(num), .exc_level_o(lvl),
    .exc_fetch_addr_o(fetch), .exc_handler_o(hdl), .vector_base_offset_reg_o(base),
    .pending_o(pend), .active_o(act), .cfg_err_o(err));
  evpu_cpu_model u_evpu_cpu_model (.clk_i(clk_i), .resetn_i(resetn_i), .exc_req_i(req),
    .exc_num_i(num), .exc_handler_i(hdl), .delay_i(dly), .core_ack_o(ack),
    .last_num_o(lnum), .last_handler_o(lhdl), .takes_o(takes));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report;
    if (fail_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic take(input logic [5:0] exp);
    int n;
    n = takes;
    dly = 2'($random(seed));
    for (int i = 0; i < 60 && takes == n; i++) @(negedge clk_i);
    if (takes == n) begin
      cmp("take timeout", 32'h0000_0001, 32'h0000_0000);
      final_report;
    end else begin
      cmp("taken vector", {26'h0, exp}, {26'h0, lnum});
      cmp("active bit", 32'h0000_0001, {31'h0, act[exp]});
      cmp("fetch address", eb + {24'h0, exp, 2'b00}, fetch);
    end
  endtask
  task automatic give_back(input logic [5:0] v);
    rnum = v;
    ret = 1'b1;
    @(negedge clk_i) ret = 1'b0;
  endtask
  task automatic pulse(input logic [47:0] m, input logic [15:0] s);
    irq = m;
    sys = s;
    @(negedge clk_i) irq = 48'h0;
    sys = 16'h0;
  endtask
  function automatic logic base_ok(input logic [31:0] v, input logic p);
    return p && v >= `EVPU_BASE_MIN && v <= `EVPU_BASE_MAX;
  endfunction
  task automatic base_wr(input logic [31:0] v, input logic p);
    if (base_ok(v, p)) eb = {v[31:8], 8'h00};
    {bval, priv, bwr} = {v, p, 1'b1};
    @(negedge clk_i) bwr = 1'b0;
    cmp("base", eb, base);
    cmp("base refused", {31'h0, !base_ok(v, p)}, {31'h0, err});
    @(negedge clk_i);
  endtask
  task automatic prio_wr(input logic [5:0] v, input logic [2:0] p, input logic ok);
    {pnum, pval, priv, pwr} = {v, p, 2'b11};
    @(negedge clk_i) pwr = 1'b0;
    cmp("prio refused", {31'h0, !ok}, {31'h0, err});
    @(negedge clk_i);
  endtask
  initial begin
    {resetn_i, irq, sys, priv, pwr, bwr, twr, ret, dly, sub, pnum, pval, rnum} = '0;
    {bval, tdata, tidx, eb, fail_count, checks} = '0;
    seed = 32'hcbda;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i) resetn_i = 1'b1;
    take(6'h01);
    give_back(6'h01);
    {tidx, tdata, twr, priv} = {6'h10, 32'h0000_1235, 2'b11};
    @(negedge clk_i) twr = 1'b0;
    pulse(48'h0000_0000_0043, 16'h0);
    cmp("reserved pending", 32'h0, {31'h0, pend[22]});
    take(6'h10);
    cmp("handler", 32'h0000_1235, lhdl);
    give_back(6'h10);
    take(6'h11);
    give_back(6'h11);
    prio_wr(6'h02, 3'h3, 1'b0);
    prio_wr(6'h16, 3'h3, 1'b0);
    base_wr(32'h2000_0100, 1'b1);
    for (int j = 0; j < 32; j++) base_wr(32'h0000_0100 << j, 1'($random(seed)));
    base_wr(32'h2000_01FF, 1'b1);
    base_wr(32'h0000_00FF, 1'b1);
    base_wr(32'h3FFF_FF00, 1'b1);
    base_wr(32'h3FFF_FF80, 1'b1);
    for (k = 0; k < 12; k++) begin
      a = $unsigned($random(seed)) % 6;
      b = 7 + $unsigned($random(seed)) % 6;
      {pa, pb} = 6'($random(seed));
      prio_wr(6'(16 + a), pa, 1'b1);
      prio_wr(6'(16 + b), pb, 1'b1);
      pulse((48'h1 << a) | (48'h1 << b), 16'h0);
      f = (pb < pa) ? b : a;
      take(6'(16 + f));
      give_back(6'(16 + f));
      take(6'(16 + a + b - f));
      give_back(6'(16 + a + b - f));
    end
    prio_wr(6'h10, 3'h4, 1'b1);
    prio_wr(6'h11, 3'h4, 1'b1);
    prio_wr(6'h12, 3'h1, 1'b1);
    pulse(48'h1, 16'h0);
    take(6'h10);
    pulse(48'h2, 16'h0);
    repeat (8) @(negedge clk_i);
    cmp("equal level withheld", {31'h0, 1'b1}, {31'h0, pend[17] & !req});
    pulse(48'h4, 16'h0);
    take(6'h12);
    pulse(48'h0, 16'h000C);
    take(6'h02);
    give_back(6'h02);
    take(6'h03);
    give_back(6'h03);
    give_back(6'h12);
    @(negedge clk_i);
    give_back(6'h10);
    take(6'h11);
    give_back(6'h11);
    prio_wr(6'h10, 3'h5, 1'b1);
    prio_wr(6'h12, 3'h4, 1'b1);
    sub = 2'h1;
    pulse(48'h1, 16'h0);
    take(6'h10);
    pulse(48'h4, 16'h0);
    repeat (4) @(negedge clk_i);
    cmp("same group withheld", {31'h0, 1'b1}, {31'h0, pend[18] & !req});
    give_back(6'h10);
    take(6'h12);
    give_back(6'h12);
    @(negedge clk_i) resetn_i = 1'b0;
    eb = 32'h0000_0000;
    @(negedge clk_i) resetn_i = 1'b1;
    cmp("base after reset", 32'h0000_0000, base);
    take(6'h01);
    final_report;
  end
endmodule // tb_top
`default_nettype wire
